// *** hw/bus_phase_pkg.sv ***
// Contract
// R1: five phases in fixed order, every access
// R2: phase lengths from selected chip-select timing
// R3: setup 1-2 periods, plus 0-3 on window change
// R4: command delay 0-3 periods, zero skips
// R5: write setup or tristate 0 or 1
// R6: access 1 to 32 periods, never zero
// R7: hold 0-3 periods, address and data driven
// R8: ready handshake extends access until ready seen
// R9: count whole periods, advance after count expires
// R10: reset abandons cycle, idle, no strobes
package bus_phase_pkg;
    localparam int NUM_CS = 4;
    localparam int CS_W = 2;
    // register offsets (index = byte address / 4)
    localparam logic [3:0] TIMING_BASE_IDX = 4'h0; // timing config for cs 0..3 at 0..3
    localparam logic [3:0] STATUS_IDX = 4'h4;
    // timing config field positions
    localparam int AB_LSB = 0;      // setup length - 1, 1 bit
    localparam int WIN_LSB = 1;     // window-change extension, 2 bits
    localparam int C_LSB = 3;       // command delay, 2 bits
    localparam int D_LSB = 5;       // write setup / tristate, 1 bit
    localparam int E_LSB = 6;       // access length - 1, 5 bits
    localparam int F_LSB = 11;      // hold, 2 bits
    localparam int RDY_LSB = 13;    // ready handshake enable
    localparam logic [13:0] TIMING_RESET = 14'h0000;
    localparam logic [4:0] WIN_SHIFT = 5'h0C; // address bits above this form the window
    typedef enum logic [2:0] {
        PH_IDLE, PH_SETUP, PH_CMD, PH_WSETUP, PH_ACCESS, PH_HOLD
    } phase_t;
    typedef struct packed {
        logic rdy_en;
        logic [1:0] hold_len;
        logic [4:0] access_m1;
        logic wsetup_len;
        logic [1:0] cmd_len;
        logic [1:0] win_ext;
        logic setup_m1;
    } timing_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic write;
        logic [CS_W-1:0] cs;
    } request_t;
endpackage

// *** hw/bus_phase_timer.sv ***
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module bus_phase_timer (
    input wire logic clk, // 40 mhz controller clock
    input wire logic srst, // sync reset, active high
    input wire logic [3:0] reg_addr, // register index
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic req_valid, // access request
    input wire bus_phase_pkg::request_t req, // access fields
    output logic req_ready, // request taken when idle
    output logic done, // one-cycle pulse at end of access
    input wire logic ready_in, // external ready, high = finish
    output bus_phase_pkg::phase_t phase, // current phase
    output logic [23:0] addr_out, // address, held through hold
    output logic [15:0] wdata_out, // write data
    output logic wdata_oe, // write data driven
    output logic [bus_phase_pkg::NUM_CS-1:0] cs_out, // chip selects, high active
    output logic rd_strobe, // read command
    output logic wr_strobe // write command
);
    bus_phase_pkg::timing_t timing_reg [bus_phase_pkg::NUM_CS];
    bus_phase_pkg::phase_t phase_reg, phase_next;
    bus_phase_pkg::request_t cur_reg;
    bus_phase_pkg::timing_t t_cur;
    logic [4:0] cnt_reg, cnt_next;
    logic [23:0] last_win_reg;
    logic [31:0] rdata_reg;
    logic [2:0] setup_len;
    logic win_change;
    logic cnt_last;
    logic take;

    // register decode
    wire is_timing = reg_addr < 4'(bus_phase_pkg::NUM_CS);
    wire [bus_phase_pkg::CS_W-1:0] reg_cs = reg_addr[bus_phase_pkg::CS_W-1:0];
    wire [31:0] rd_mux = is_timing ? {18'h0, timing_reg[reg_cs]} :
        (reg_addr == bus_phase_pkg::STATUS_IDX) ?
        {26'h0, cur_reg.cs, 1'b0, phase_reg} : 32'h0;

    // active timing set follows the latched chip select
    assign t_cur = timing_reg[cur_reg.cs]; // [R2]
    assign take = req_valid && (phase_reg == bus_phase_pkg::PH_IDLE);
    assign req_ready = (phase_reg == bus_phase_pkg::PH_IDLE);
    assign win_change = (req.addr >> bus_phase_pkg::WIN_SHIFT) != last_win_reg; // [R3]
    assign cnt_last = (cnt_reg == 5'h00);

    // setup length 1 or 2 plus window extension, held as count - 1
    always_comb begin
        setup_len = {2'h0, timing_reg[req.cs].setup_m1}; // [R3]
        if (win_change) begin
            setup_len = setup_len + {1'b0, timing_reg[req.cs].win_ext};
        end
    end

    // phase sequencer, moves on the edge after the count expires
    always_comb begin
        phase_next = phase_reg;
        cnt_next = cnt_reg - 5'h01; // [R9]
        case (phase_reg)
            bus_phase_pkg::PH_IDLE: begin
                cnt_next = 5'h00;
                if (req_valid) begin
                    phase_next = bus_phase_pkg::PH_SETUP; // [R1]
                    cnt_next = {2'h0, setup_len};
                end
            end
            bus_phase_pkg::PH_SETUP: begin
                if (cnt_last) begin
                    if (t_cur.cmd_len != 2'h0) begin // [R4]
                        phase_next = bus_phase_pkg::PH_CMD;
                        cnt_next = {3'h0, t_cur.cmd_len} - 5'h01;
                    end else if (t_cur.wsetup_len) begin // [R5]
                        phase_next = bus_phase_pkg::PH_WSETUP;
                        cnt_next = 5'h00;
                    end else begin
                        phase_next = bus_phase_pkg::PH_ACCESS;
                        cnt_next = t_cur.access_m1; // [R6]
                    end
                end
            end
            bus_phase_pkg::PH_CMD: begin
                if (cnt_last) begin
                    if (t_cur.wsetup_len) begin // [R5]
                        phase_next = bus_phase_pkg::PH_WSETUP;
                        cnt_next = 5'h00;
                    end else begin
                        phase_next = bus_phase_pkg::PH_ACCESS;
                        cnt_next = t_cur.access_m1;
                    end
                end
            end
            bus_phase_pkg::PH_WSETUP: begin
                phase_next = bus_phase_pkg::PH_ACCESS;
                cnt_next = t_cur.access_m1; // [R6]
            end
            bus_phase_pkg::PH_ACCESS: begin
                if (cnt_last) begin
                    cnt_next = 5'h00;
                    if (!t_cur.rdy_en || ready_in) begin // [R8]
                        if (t_cur.hold_len != 2'h0) begin // [R7]
                            phase_next = bus_phase_pkg::PH_HOLD;
                            cnt_next = {3'h0, t_cur.hold_len} - 5'h01;
                        end else begin
                            phase_next = bus_phase_pkg::PH_IDLE;
                        end
                    end
                end
            end
            bus_phase_pkg::PH_HOLD: begin
                if (cnt_last) begin
                    phase_next = bus_phase_pkg::PH_IDLE;
                    cnt_next = 5'h00;
                end
            end
            default: begin
                phase_next = bus_phase_pkg::PH_IDLE;
                cnt_next = 5'h00;
            end
        endcase
    end

    // access finishes when leaving access or hold toward idle
    assign done = (phase_reg != bus_phase_pkg::PH_IDLE) &&
        (phase_next == bus_phase_pkg::PH_IDLE);

    // sequencer state, reset abandons the cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_reg <= bus_phase_pkg::PH_IDLE; // [R10]
            cnt_reg <= 5'h00;
        end else begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
        end
    end

    // latch request and remember address window
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_reg <= '0;
            last_win_reg <= 24'h000000;
        end else if (take) begin
            cur_reg <= req;
            last_win_reg <= req.addr >> bus_phase_pkg::WIN_SHIFT;
        end
    end

    // timing configuration registers and read port
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < bus_phase_pkg::NUM_CS; i++) begin
                timing_reg[i] <= bus_phase_pkg::TIMING_RESET;
            end
            rdata_reg <= 32'h0;
        end else begin
            if (reg_wr && is_timing) begin
                timing_reg[reg_cs] <= reg_wdata[13:0]; // [R2]
            end
            rdata_reg <= reg_rd ? rd_mux : 32'h0;
        end
    end
    assign reg_rdata = rdata_reg;

    // pin outputs from flip-flops, derived from next phase
    logic busy_next;
    assign busy_next = phase_next != bus_phase_pkg::PH_IDLE;
    logic [23:0] addr_reg;
    logic [15:0] wd_reg;
    logic wd_oe_reg, rd_reg, wr_reg;
    logic [bus_phase_pkg::NUM_CS-1:0] cs_reg;
    bus_phase_pkg::request_t src;
    assign src = take ? req : cur_reg;
    wire in_cmd = (phase_next == bus_phase_pkg::PH_ACCESS);
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_reg <= 24'h000000;
            wd_reg <= 16'h0000;
            wd_oe_reg <= 1'b0;
            cs_reg <= '0;
            rd_reg <= 1'b0; // [R10]
            wr_reg <= 1'b0;
        end else begin
            addr_reg <= busy_next ? src.addr : addr_reg; // [R7]
            wd_reg <= src.wdata;
            wd_oe_reg <= busy_next && src.write && (phase_next != bus_phase_pkg::PH_SETUP);
            cs_reg <= busy_next ? (bus_phase_pkg::NUM_CS)'(1 << src.cs) : '0;
            rd_reg <= in_cmd && !src.write;
            wr_reg <= in_cmd && src.write;
        end
    end
    assign phase = phase_reg;
    assign addr_out = addr_reg;
    assign wdata_out = wd_reg;
    assign wdata_oe = wd_oe_reg;
    assign cs_out = cs_reg;
    assign rd_strobe = rd_reg;
    assign wr_strobe = wr_reg;
endmodule

// *** testbench/bus_phase_timer_properties.sv ***
`timescale 1ns/1ps
module bus_phase_timer_properties (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic req_valid, // request
    input wire logic req_ready, // idle flag
    input wire logic done, // end pulse
    input wire bus_phase_pkg::phase_t phase, // phase
    input wire logic [23:0] addr_out, // address
    input wire logic [bus_phase_pkg::NUM_CS-1:0] cs_out, // selects
    input wire logic rd_strobe, // read command
    input wire logic wr_strobe // write command
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // phase decode
    wire is_idle = phase == bus_phase_pkg::PH_IDLE;
    wire is_set = phase == bus_phase_pkg::PH_SETUP;
    wire is_cmd = phase == bus_phase_pkg::PH_CMD;
    wire is_ws = phase == bus_phase_pkg::PH_WSETUP;
    wire is_acc = phase == bus_phase_pkg::PH_ACCESS;
    wire is_hold = phase == bus_phase_pkg::PH_HOLD;
    // order, bounds and strobes of the phases
    a_idle_quiet: assert property (is_idle |-> !rd_strobe && !wr_strobe && !cs_out)
        else $error("strobe while idle");
    a_reset_idle: assert property ($past(srst) |-> is_idle)
        else $error("not idle after reset");
    a_take_setup: assert property (req_valid && req_ready |=> is_set)
        else $error("access did not start");
    a_setup_exit: assert property (is_set ##1 !is_set |-> is_cmd || is_ws || is_acc)
        else $error("bad phase after setup");
    a_setup_max: assert property (is_set [*5] |=> !is_set)
        else $error("setup too long");
    a_cmd_max: assert property (is_cmd [*3] |=> !is_cmd)
        else $error("command delay too long");
    a_ws_one: assert property (is_ws |=> is_acc)
        else $error("write setup not one cycle");
    a_acc_first: assert property (is_hold |-> $past(is_acc) || $past(is_hold))
        else $error("access skipped");
    a_acc_strobe: assert property (is_acc |-> rd_strobe ^ wr_strobe)
        else $error("no command in access");
    a_hold_addr: assert property (is_hold |-> $stable(addr_out) && cs_out != '0)
        else $error("address moved in hold");
    a_hold_max: assert property (is_hold [*3] |=> is_idle)
        else $error("hold too long");
    a_done_end: assert property (done |=> is_idle)
        else $error("done not last cycle");
    a_done_seen: assert property (!is_idle ##1 is_idle |-> $past(done))
        else $error("access ended without done");
    a_strobe_only: assert property (rd_strobe || wr_strobe |-> is_acc)
        else $error("command outside access");
    c_cmd: cover property (is_cmd);
    c_ws: cover property (is_ws);
    c_hold: cover property (is_hold [*3]);
endmodule
bind bus_phase_timer bus_phase_timer_properties u_props (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req_ready(req_ready), .done(done), .phase(phase),
    .addr_out(addr_out), .cs_out(cs_out), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe));

// *** testbench/bus_phase_timer_tb.sv ***
`timescale 1ns/1ps
module bus_phase_timer_tb;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    bus_phase_pkg::request_t req = '0;
    bus_phase_pkg::phase_t phase;
    logic req_ready, done, ready_in, rd_strobe, wr_strobe, wdata_oe;
    logic [23:0] addr_out;
    logic [15:0] wdata_out;
    logic [3:0] cs_out;
    logic [5:0] wait_cycles = 6'h05;
    int fails = 0, checks = 0, cyc = 0;
    int n [6];
    always #12.5 clk = ~clk;
    bus_phase_timer u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .done(done), .ready_in(ready_in), .phase(phase),
        .addr_out(addr_out), .wdata_out(wdata_out), .wdata_oe(wdata_oe), .cs_out(cs_out),
        .rd_strobe(rd_strobe), .wr_strobe(wr_strobe));
    ext_ready_model u_ext (.clk(clk), .phase(phase), .wait_cycles(wait_cycles),
        .ready_in(ready_in));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // register bus cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    // issue one access, count cycles per phase
    task automatic access(input logic [23:0] a, input logic w, input logic [1:0] cs);
        int last = 0;
        foreach (n[i]) n[i] = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{addr: a, wdata: 16'hA5C3, write: w, cs: cs};
        @(posedge clk);
        req_valid <= 1'b0;
        #1 check(cs_out, 4'h1 << cs);
        check({wdata_oe, addr_out}, {1'b0, a});
        check(wdata_out, 16'hA5C3);
        for (int k = 0; k < 100 && phase !== bus_phase_pkg::PH_IDLE; k++) begin
            check(32'(int'(phase) >= last), 32'h1);
            if (phase === bus_phase_pkg::PH_ACCESS)
                check({rd_strobe, wr_strobe, wdata_oe}, {!w, w, w});
            if (phase === bus_phase_pkg::PH_HOLD)
                check({wdata_oe, addr_out}, {w, a});
            last = int'(phase);
            n[phase]++;
            @(posedge clk);
            #1;
        end
    endtask
    task automatic counts(input int s, input int c, input int w, input int e, input int h);
        check(n[1], s);
        check(n[2], c);
        check(n[3], w);
        check(n[4], e);
        check(n[5], h);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(4'h1, 32'h0);
        rd(4'h5, 32'h0);
        access(24'h000010, 1'b1, 2'h0);
        counts(1, 0, 0, 1, 0);
        wr(4'h1, 32'h00001FFF);
        rd(4'h1, 32'h00001FFF);
        access(24'h005000, 1'b0, 2'h1);
        counts(5, 3, 1, 32, 3);
        access(24'h005FFE, 1'b1, 2'h1);
        counts(2, 3, 1, 32, 3);
        wr(4'h2, 32'h00002040);
        access(24'h005000, 1'b0, 2'h2);
        counts(1, 0, 0, 6, 0);
        wait_cycles <= 6'h00;
        access(24'h005004, 1'b1, 2'h2);
        counts(1, 0, 0, 2, 0);
        rd(4'h4, 32'h00000020);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{addr: 24'h005008, wdata: 16'h0F0F, write: 1'b1, cs: 2'h1};
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (8) @(posedge clk);
        srst <= 1'b1;
        #1 check({wr_strobe, cs_out}, 32'h12);
        @(posedge clk);
        srst <= 1'b0;
        #1 check(phase, bus_phase_pkg::PH_IDLE);
        check({cs_out, rd_strobe, wr_strobe}, 32'h0);
        rd(4'h1, 32'h0);
        access(24'h000020, 1'b0, 2'h3);
        counts(1, 0, 0, 1, 0);
        give_verdict();
    end
endmodule

// *** testbench/ext_ready_model.sv ***
`timescale 1ns/1ps
module ext_ready_model (
    input wire logic clk, // clock
    input wire bus_phase_pkg::phase_t phase, // device phase
    input wire logic [5:0] wait_cycles, // access cycles before ready
    output logic ready_in // ready to device
);
    logic [5:0] cnt_reg = 6'h00;
    logic tog_reg = 1'b0;
    // count access cycles, junk outside access
    always_ff @(posedge clk) begin
        cnt_reg <= (phase == bus_phase_pkg::PH_ACCESS) ? cnt_reg + 6'h01 : 6'h00;
        tog_reg <= !tog_reg;
    end
    // ready once the wait has run out
    assign ready_in = (phase == bus_phase_pkg::PH_ACCESS) ? cnt_reg >= wait_cycles : tog_reg;
endmodule
